//--- logic/uodio_pkg.sv
// Constants, register map and state codes for the IO-pin routing and
// object detection block.
// Assumes a single 10 MHz system clock shared by every file that imports it.
package uodio_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ           = 10_000_000;
  localparam int TOF_UNIT_NS      = 1000;
  localparam int WIDTH_UNIT_US    = 4;
  localparam int US_CYCLES        = (TOF_UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] US_CNT_MAX  = 4'(US_CYCLES - 1);
  localparam logic [1:0] WIDTH_SUB_MAX = 2'(WIDTH_UNIT_US - 1);
  localparam int REC_UNIT_SHIFT   = 8;

  // ************************************************************
  // Objects
  // ************************************************************
  localparam int OBJ_MAX          = 8;
  localparam logic [3:0] OBJ_MAX_CNT = 4'(OBJ_MAX);
  localparam logic [7:0] WIDTH_SAT   = 8'hFE;
  localparam logic [7:0] ALL_ONES8   = 8'hFF;
  localparam logic [15:0] ALL_ONES16 = 16'hFFFF;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [5:0] ADDR_CTRL     = 6'h00;
  localparam logic [5:0] ADDR_STATUS   = 6'h01;
  localparam logic [5:0] ADDR_P1_REC   = 6'h02;
  localparam logic [5:0] ADDR_P2_REC   = 6'h03;
  localparam logic [5:0] ADDR_OBJ_REQ  = 6'h04;
  localparam logic [5:0] ADDR_OBJ_BASE = 6'h10;
  localparam logic [5:0] ADDR_OBJ_END  = 6'h30;

  localparam int CTRL_ROUTE_BIT  = 0;
  localparam int CTRL_DUMP_BIT   = 1;
  localparam int STAT_TOGGLE_BIT = 0;
  localparam int STAT_READY_BIT  = 1;
  localparam int STAT_BUSY_BIT   = 2;

  localparam logic [7:0] P1_REC_RST  = 8'h0F;
  localparam logic [7:0] P2_REC_RST  = 8'h0F;
  localparam logic [2:0] OBJ_REQ_RST = 3'h7;

  // ************************************************************
  // Toggle pattern bytes
  // ************************************************************
  localparam logic [7:0] TOG_BYTE0 = 8'hF0;
  localparam logic [7:0] TOG_BYTE1 = 8'hF8;
  localparam logic [7:0] TOG_BYTE2 = 8'hFC;

  typedef enum logic [2:0] {
    DET_IDLE       = 3'b000,
    DET_WAIT_BURST = 3'b001,
    DET_WAIT_BELOW = 3'b010,
    DET_RECORD     = 3'b011,
    DET_DONE       = 3'b100
  } uodio_det_e;

  typedef enum logic [1:0] {
    TOG_IDLE = 2'b00,
    TOG_GOT0 = 2'b01,
    TOG_GOT1 = 2'b10
  } uodio_tog_e;

endpackage

//--- logic/uodio_toggle_det.sv
// Recognises the IO-pin interface toggle pattern in either pin mode.
// Assumes bytes from a receiver listening on the IO pin and a pulse from
// the time-command decoder when its three-pulse pattern is seen.
`timescale 1ns/1ps
module uodio_toggle_det
  import uodio_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       route_uart,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       tci_pattern,
  output logic            toggle_pulse
);
  import uodio_pkg::*;

  uodio_tog_e tog_state_reg;

  // ************************************************************
  // Byte sequence while the pin is in time-command mode
  // ************************************************************
  // A wrong byte restarts the search, but a stray first byte is reused.
  always_ff @(posedge sys_clk) begin
    if (reset || route_uart) begin
      tog_state_reg <= TOG_IDLE;
    end else if (byte_valid) begin
      case (tog_state_reg)
        TOG_IDLE: tog_state_reg <= (byte_data == TOG_BYTE0) ? TOG_GOT0 : TOG_IDLE;
        TOG_GOT0: tog_state_reg <= (byte_data == TOG_BYTE1) ? TOG_GOT1 :
                                   (byte_data == TOG_BYTE0) ? TOG_GOT0 : TOG_IDLE;
        TOG_GOT1: tog_state_reg <= (byte_data == TOG_BYTE0) ? TOG_GOT0 : TOG_IDLE;
        default:  tog_state_reg <= TOG_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      toggle_pulse <= 1'b0;
    end else begin
      toggle_pulse <= (!route_uart && byte_valid && tog_state_reg == TOG_GOT1 &&
                       byte_data == TOG_BYTE2) ||
                      (route_uart && tci_pattern);
    end
  end

  a_seq_toggle: assert property (@(posedge sys_clk) disable iff (reset)
    (!route_uart && byte_valid && tog_state_reg == TOG_GOT1 && byte_data == TOG_BYTE2)
    |=> toggle_pulse)
    else $error("Toggle byte sequence not recognised.");

  a_tci_toggle: assert property (@(posedge sys_clk) disable iff (reset)
    toggle_pulse |-> $past(tci_pattern) || $past(byte_valid))
    else $error("Toggle pulse without a cause.");

endmodule

//--- logic/uodio_top.sv
// IO-pin UART routing, interface toggling and ultrasonic object detection.
// Assumes synchronous inputs, a UART core beside it and a DSP envelope feed.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module uodio_top
  import uodio_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic [7:0]      reg_rdata,
  input  wire logic       uart_txd_int,
  input  wire logic       uart_tx_busy,
  output logic            uart_rxd_int,
  input  wire logic       sync_mode,
  input  wire logic       rxd_pin,
  input  wire logic       rxd_floating,
  output logic            txd_pin,
  output logic            dedicated_xcvr_en,
  input  wire logic       io_in,
  output logic            io_out,
  output logic            io_oe,
  input  wire logic       tci_drive_low,
  input  wire logic       io_byte_valid,
  input  wire logic [7:0] io_byte,
  input  wire logic       tci_pattern,
  input  wire logic       run_start,
  input  wire logic       run_listen_only,
  input  wire logic       run_preset2,
  input  wire logic       burst_done,
  input  wire logic [7:0] echo_amp,
  input  wire logic [7:0] echo_thr,
  output logic            one_wire_link,
  output logic            results_ready
);
  import uodio_pkg::*;

  // ************************************************************
  // Control registers
  // ************************************************************
  logic       route_reg;
  logic       echo_dump_enable;
  logic [7:0] p1_rec_reg;
  logic [7:0] p2_rec_reg;
  logic [2:0] obj_req_reg;
  logic       pattern_toggle_flag;
  logic       toggle_pulse;

  uodio_toggle_det u_toggle (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .route_uart   (route_reg),
    .byte_valid   (io_byte_valid),
    .byte_data    (io_byte),
    .tci_pattern  (tci_pattern),
    .toggle_pulse (toggle_pulse)
  );

  // Only the working copy flips; persisting it is the controller's job.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      route_reg <= 1'b0;
    end else if (toggle_pulse) begin
      route_reg <= ~route_reg;
    end else if (reg_we && reg_addr == ADDR_CTRL) begin
      route_reg <= reg_wdata[CTRL_ROUTE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      echo_dump_enable <= 1'b0;
      p1_rec_reg       <= P1_REC_RST;
      p2_rec_reg       <= P2_REC_RST;
      obj_req_reg      <= OBJ_REQ_RST;
    end else if (reg_we) begin
      if (reg_addr == ADDR_CTRL) begin
        echo_dump_enable <= reg_wdata[CTRL_DUMP_BIT];
      end
      if (reg_addr == ADDR_P1_REC) begin
        p1_rec_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_P2_REC) begin
        p2_rec_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_OBJ_REQ) begin
        obj_req_reg <= reg_wdata[2:0];
      end
    end
  end

  // A toggle in the same cycle as the clearing read survives.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pattern_toggle_flag <= 1'b0;
    end else if (toggle_pulse) begin
      pattern_toggle_flag <= 1'b1;
    end else if (reg_re && reg_addr == ADDR_STATUS) begin
      pattern_toggle_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Pin routing
  // ************************************************************
  logic io_uart_on;
  logic ded_off;
  logic io_rx_bit;

  assign io_uart_on = route_reg && !sync_mode;
  assign ded_off    = route_reg && rxd_floating;
  // Our own drive is masked from the receiver, so a frame never echoes back.
  assign io_rx_bit  = uart_tx_busy ? 1'b1 : io_in;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uart_rxd_int <= 1'b1;
    end else if (io_uart_on) begin
      uart_rxd_int <= ded_off ? io_rx_bit : (io_rx_bit & rxd_pin);
    end else begin
      uart_rxd_int <= rxd_pin;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txd_pin           <= 1'b1;
      dedicated_xcvr_en <= 1'b1;
    end else begin
      txd_pin           <= (ded_off && !sync_mode) ? 1'b1 : uart_txd_int;
      dedicated_xcvr_en <= !(ded_off && !sync_mode);
    end
  end

  // Open drain: the pin is only ever pulled low.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_out <= 1'b0;
      io_oe  <= 1'b0;
    end else begin
      io_out <= 1'b0;
      if (route_reg) begin
        io_oe <= io_uart_on && uart_tx_busy && !uart_txd_int;
      end else begin
        io_oe <= tci_drive_low;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      one_wire_link <= 1'b0;
    end else begin
      one_wire_link <= io_uart_on;
    end
  end

  // ************************************************************
  // Detection timing
  // ************************************************************
  uodio_det_e  det_state_reg;
  logic [3:0]  us_pre_reg;
  logic        us_tick;
  logic [16:0] rec_cnt_reg;
  logic [16:0] rec_limit;
  logic        rec_end;
  logic [15:0] time_us_reg;
  logic        above;
  logic        active;

  assign us_tick = (us_pre_reg == US_CNT_MAX);
  assign above   = echo_amp > echo_thr;
  assign active  = det_state_reg == DET_WAIT_BURST ||
                   det_state_reg == DET_WAIT_BELOW || det_state_reg == DET_RECORD;
  assign rec_limit = (17'(run_preset2 ? p2_rec_reg : p1_rec_reg) + 17'd1) << REC_UNIT_SHIFT;
  assign rec_end = active && us_tick && (rec_cnt_reg + 17'd1 >= rec_limit);

  always_ff @(posedge sys_clk) begin
    if (reset || run_start || us_tick) begin
      us_pre_reg <= 4'h0;
    end else begin
      us_pre_reg <= us_pre_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || run_start) begin
      rec_cnt_reg <= 17'h00000;
    end else if (active && us_tick) begin
      rec_cnt_reg <= rec_cnt_reg + 17'd1;
    end
  end

  // Time of flight restarts on entry to recording.
  always_ff @(posedge sys_clk) begin
    if (reset || run_start || det_state_reg != DET_RECORD) begin
      time_us_reg <= 16'h0000;
    end else if (us_tick) begin
      time_us_reg <= time_us_reg + 16'h0001;
    end
  end

  // ************************************************************
  // Object tracking
  // ************************************************************
  logic [3:0]  obj_idx_reg;
  logic [3:0]  obj_req_cnt;
  logic        in_obj_reg;
  logic [15:0] tof_hold_reg;
  logic [7:0]  width_cnt_reg;
  logic [1:0]  width_sub_reg;
  logic [7:0]  peak_reg;
  logic        cross_up;
  logic        close_evt;
  logic        early_done;
  logic [7:0]  width_final;
  logic [7:0]  peak_final;

  assign obj_req_cnt = {1'b0, obj_req_reg} + 4'h1;
  assign cross_up = det_state_reg == DET_RECORD && !echo_dump_enable && !in_obj_reg &&
                    above && obj_idx_reg < obj_req_cnt;
  assign close_evt = det_state_reg == DET_RECORD && in_obj_reg && (!above || rec_end);
  assign early_done = close_evt && !rec_end && (obj_idx_reg + 4'h1 == obj_req_cnt);
  assign width_final = rec_end ? ALL_ONES8 : width_cnt_reg;
  assign peak_final = (echo_amp > peak_reg) ? echo_amp : peak_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      det_state_reg <= DET_IDLE;
    end else if (run_start) begin
      if (echo_dump_enable) begin
        det_state_reg <= DET_DONE;
      end else begin
        det_state_reg <= run_listen_only ? DET_RECORD : DET_WAIT_BURST;
      end
    end else if (rec_end || early_done) begin
      det_state_reg <= DET_DONE;
    end else begin
      case (det_state_reg)
        DET_WAIT_BURST: det_state_reg <= burst_done ? DET_WAIT_BELOW : DET_WAIT_BURST;
        DET_WAIT_BELOW: det_state_reg <= above ? DET_WAIT_BELOW : DET_RECORD;
        DET_RECORD:     det_state_reg <= DET_RECORD;
        DET_DONE:       det_state_reg <= DET_DONE;
        DET_IDLE:       det_state_reg <= DET_IDLE;
        default:        det_state_reg <= DET_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || run_start) begin
      obj_idx_reg  <= 4'h0;
      in_obj_reg   <= 1'b0;
      tof_hold_reg <= 16'h0000;
    end else if (cross_up) begin
      in_obj_reg   <= 1'b1;
      tof_hold_reg <= time_us_reg;
    end else if (close_evt) begin
      in_obj_reg  <= 1'b0;
      obj_idx_reg <= obj_idx_reg + 4'h1;
    end
  end

  // Width saturates one below all ones so an open object stays distinct.
  always_ff @(posedge sys_clk) begin
    if (reset || cross_up || !in_obj_reg) begin
      width_cnt_reg <= 8'h00;
      width_sub_reg <= 2'h0;
      peak_reg      <= echo_amp;
    end else begin
      peak_reg <= peak_final;
      if (us_tick) begin
        width_sub_reg <= width_sub_reg + 2'h1;
        if (width_sub_reg == WIDTH_SUB_MAX && width_cnt_reg != WIDTH_SAT) begin
          width_cnt_reg <= width_cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || run_start) begin
      results_ready <= 1'b0;
    end else if (rec_end || early_done || det_state_reg == DET_DONE) begin
      results_ready <= 1'b1;
    end
  end

  // ************************************************************
  // Result slots
  // ************************************************************
  logic [15:0] slot_tof   [OBJ_MAX];
  logic [7:0]  slot_width [OBJ_MAX];
  logic [7:0]  slot_peak  [OBJ_MAX];

  // Slots are written once per run, so repeated reads agree.
  for (genvar gi = 0; gi < OBJ_MAX; gi++) begin : g_slot
    always_ff @(posedge sys_clk) begin
      if (reset || run_start) begin
        slot_tof[gi]   <= ALL_ONES16;
        slot_width[gi] <= ALL_ONES8;
        slot_peak[gi]  <= ALL_ONES8;
      end else if (close_evt && obj_idx_reg == 4'(gi)) begin
        slot_tof[gi]   <= tof_hold_reg;
        slot_width[gi] <= width_final;
        slot_peak[gi]  <= peak_final;
      end
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  function automatic logic obj_hit(input logic [5:0] addr);
    obj_hit = (addr >= ADDR_OBJ_BASE) && (addr < ADDR_OBJ_END);
  endfunction

  logic [5:0] obj_off;
  logic [7:0] rd_value;

  assign obj_off = reg_addr - ADDR_OBJ_BASE;

  always_comb begin
    rd_value = 8'h00;
    if (obj_hit(reg_addr)) begin
      case (obj_off[1:0])
        2'h0:    rd_value = slot_tof[obj_off[4:2]][7:0];
        2'h1:    rd_value = slot_tof[obj_off[4:2]][15:8];
        2'h2:    rd_value = slot_width[obj_off[4:2]];
        default: rd_value = slot_peak[obj_off[4:2]];
      endcase
    end else begin
      case (reg_addr)
        ADDR_CTRL:    rd_value = {6'h00, echo_dump_enable, route_reg};
        ADDR_STATUS:  rd_value = {5'h00, active, results_ready, pattern_toggle_flag};
        ADDR_P1_REC:  rd_value = p1_rec_reg;
        ADDR_P2_REC:  rd_value = p2_rec_reg;
        ADDR_OBJ_REQ: rd_value = {5'h00, obj_req_reg};
        default:      rd_value = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_re ? rd_value : 8'h00;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_route_rx_io: assert property (@(posedge sys_clk) disable iff (reset)
    (io_uart_on && rxd_floating && !uart_tx_busy) |=> uart_rxd_int == $past(io_in))
    else $error("IO pin not routed to UART receiver.");

  a_half_duplex: assert property (@(posedge sys_clk) disable iff (reset)
    (io_oe && one_wire_link) |-> $past(uart_tx_busy))
    else $error("IO pin driven while not transmitting.");

  a_ded_off: assert property (@(posedge sys_clk) disable iff (reset)
    (ded_off && !sync_mode) |=> (txd_pin && !dedicated_xcvr_en))
    else $error("Dedicated transceiver still active.");

  a_sync_io_off: assert property (@(posedge sys_clk) disable iff (reset)
    (route_reg && sync_mode) |=> !io_oe)
    else $error("IO transceiver active in sync mode.");

  a_obj_limit: assert property (@(posedge sys_clk) disable iff (reset)
    obj_idx_reg <= OBJ_MAX_CNT)
    else $error("More than eight objects recorded.");

  a_dump_nodet: assert property (@(posedge sys_clk) disable iff (reset)
    (echo_dump_enable && !run_start) |=> $stable(obj_idx_reg) && !$rose(in_obj_reg))
    else $error("Detection ran during echo dump.");

  a_thr_cross: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(in_obj_reg) |-> $past(echo_amp) > $past(echo_thr))
    else $error("Object declared below threshold.");

  a_run_start: assert property (@(posedge sys_clk) disable iff (reset)
    (run_start && !echo_dump_enable && !run_listen_only) |=> det_state_reg == DET_WAIT_BURST)
    else $error("Run command not started at once.");

  a_listen_rec: assert property (@(posedge sys_clk) disable iff (reset)
    (run_start && !echo_dump_enable && run_listen_only)
    |=> (det_state_reg == DET_RECORD && time_us_reg == 16'h0000))
    else $error("Listen only did not start at record start.");

  a_early_done: assert property (@(posedge sys_clk) disable iff (reset)
    (early_done && !run_start) |=> (det_state_reg == DET_DONE ##1 results_ready))
    else $error("Record not ended after requested objects.");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_re && reg_addr == ADDR_STATUS && !toggle_pulse) |=> !pattern_toggle_flag)
    else $error("Toggle flag not cleared by read.");

  a_toggle_inv: assert property (@(posedge sys_clk) disable iff (reset)
    toggle_pulse |=> (route_reg != $past(route_reg)) && pattern_toggle_flag)
    else $error("Toggle did not invert route bit.");

  a_reset_route: assert property (@(posedge sys_clk)
    reset |=> !route_reg && !one_wire_link)
    else $error("Route bit not cleared by reset.");

endmodule

//--- tb/uodio_partner.sv
// Controller model on the shared IO pin: sends the toggle bytes as a
// receiver would hand them over, and pulls the open-drain line low.
// Assumes the same 10 MHz clock as the device and a pull-up on the pin.
`timescale 1ns/1ps
module uodio_partner (
  input  wire logic       sys_clk,
  input  wire logic       send_pat,
  input  wire logic       host_low,
  input  wire logic       dev_oe,
  output logic            io_in,
  output logic            io_byte_valid,
  output logic [7:0]      io_byte
);
  // ************************************************************
  // Pattern sender
  // ************************************************************
  // One ten-bit frame at 19200 baud lasts this many 10 MHz cycles.
  localparam int BYTE_CYC = 5208;
  logic [7:0]  pat [3] = '{8'hF0, 8'hF8, 8'hFC};
  logic [1:0]  idx     = 2'h3;
  logic [12:0] cnt     = 13'h0;
  initial begin
    io_byte_valid = 1'b0;
    io_byte = 8'h00;
  end
  // Wired-AND of both parties with the pull-up as idle level.
  assign io_in = ~(dev_oe | host_low);
  always @(posedge sys_clk) begin
    io_byte_valid <= 1'b0;
    if (io_byte_valid) begin
      io_byte <= ~io_byte;
    end
    if (send_pat) begin
      idx <= 2'h0;
      cnt <= 13'h0;
    end else if (idx != 2'h3) begin
      cnt <= cnt + 13'h1;
      if (cnt == 13'(BYTE_CYC - 1)) begin
        io_byte_valid <= 1'b1;
        io_byte <= pat[idx];
        idx <= idx + 2'h1;
        cnt <= 13'h0;
      end
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the IO routing and object detection block.
// Assumes the partner model drives the IO pin side of the design.
`timescale 1ns/1ps
module testbench;
  import uodio_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic       sys_clk = 1'b0, reset = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, echo_amp = 8'h00, io_byte, thr = 8'h40;
  logic       txd = 1'b1, busy = 1'b0, sync_mode = 1'b0, rxd_pin = 1'b1, flt = 1'b0;
  logic       tci_low = 1'b0, tci_pat = 1'b0, run = 1'b0, lo = 1'b0, p2 = 1'b0, bdone = 1'b0;
  logic       send_pat = 1'b0, host_low = 1'b0, io_in, io_bv, io_oe, link, ready;
  logic       rxd_int, txd_pin, xcvr_en, io_out;
  logic [7:0] pk;
  logic [31:0] seed = 32'h0001_8583;
  int         err_total = 0, checks_done = 0, cyc = 0;
  uodio_top uodio_top_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .uart_txd_int(txd), .uart_tx_busy(busy), .uart_rxd_int(rxd_int), .sync_mode(sync_mode),
    .rxd_pin(rxd_pin), .rxd_floating(flt), .txd_pin(txd_pin), .dedicated_xcvr_en(xcvr_en),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .tci_drive_low(tci_low),
    .io_byte_valid(io_bv), .io_byte(io_byte), .tci_pattern(tci_pat), .run_start(run),
    .run_listen_only(lo), .run_preset2(p2), .burst_done(bdone), .echo_amp(echo_amp),
    .echo_thr(thr), .one_wire_link(link), .results_ready(ready));
  uodio_partner uodio_partner_i (.sys_clk(sys_clk), .send_pat(send_pat), .host_low(host_low),
    .dev_oe(io_oe), .io_in(io_in), .io_byte_valid(io_bv), .io_byte(io_byte));
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 `CHK(n, e, reg_rdata)
  endtask
  task automatic start(input logic l);
    @(posedge sys_clk);
    run <= 1'b1;
    lo <= l;
    @(posedge sys_clk);
    run <= 1'b0;
  endtask
  task automatic wait_ready(input int lim);
    int i;
    for (i = 0; i < lim && ready !== 1'b1; i++) @(posedge sys_clk);
    `CHK("ready", 1'b1, ready)
  endtask
  task automatic close_out;
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    tick(3);
    reset <= 1'b0;
    tci_low <= 1'b1;
    tick(3);
    `CHK("link", 1'b0, link)
    `CHK("oe_tci", 1'b1, io_oe)
    tci_low <= 1'b0;
    rxd_pin <= 1'b0;
    txd <= 1'b0;
    tick(2);
    `CHK("rxd_pass", 1'b0, rxd_int)
    `CHK("txd_pass", 1'b0, txd_pin)
    `CHK("io_out", 1'b0, io_out)
    rxd_pin <= 1'b1;
    txd <= 1'b1;
    rdc(6'h3F, 8'h00, "unmapped");
    send_pat <= 1'b1;
    tick(1);
    send_pat <= 1'b0;
    tick(3 * 5208 + 8);
    `CHK("link", 1'b1, link)
    rdc(ADDR_CTRL, 8'h01, "ctrl");
    rdc(ADDR_STATUS, 8'h01, "flag");
    rdc(ADDR_STATUS, 8'h00, "flag_clr");
    flt <= 1'b1;
    busy <= 1'b1;
    repeat (8) begin
      seed = lfsr(seed);
      txd <= seed[0];
      tick(2);
      `CHK("io_oe", ~txd, io_oe)
      `CHK("xcvr", 1'b0, xcvr_en)
      `CHK("txd_pin", 1'b1, txd_pin)
    end
    busy <= 1'b0;
    txd <= 1'b1;
    tick(1);
    repeat (8) begin
      seed = lfsr(seed);
      host_low <= seed[3];
      tick(2);
      `CHK("rxd_int", ~host_low, rxd_int)
    end
    sync_mode <= 1'b1;
    busy <= 1'b1;
    txd <= 1'b0;
    tick(2);
    `CHK("sync_oe", 1'b0, io_oe)
    `CHK("sync_link", 1'b0, link)
    sync_mode <= 1'b0;
    busy <= 1'b0;
    txd <= 1'b1;
    host_low <= 1'b0;
    wr(ADDR_P1_REC, 8'h00);
    wr(ADDR_OBJ_REQ, 8'h00);
    seed = lfsr(seed);
    pk = 8'h41 | seed[7:0];
    start(1'b1);
    echo_amp <= 8'h40;
    tick(30);
    echo_amp <= 8'h00;
    tick(10);
    echo_amp <= pk;
    tick(100);
    echo_amp <= 8'h00;
    wait_ready(100);
    rdc(6'h13, pk, "peak");
    rdc(6'h11, 8'h00, "tof_hi");
    rdc(6'h10, 8'h04, "tof_lo");
    rdc(6'h12, 8'h02, "width");
    rdc(6'h14, 8'hFF, "slot1");
    rdc(6'h13, pk, "held");
    wr(ADDR_OBJ_REQ, 8'h07);
    wr(ADDR_P1_REC, 8'h0F);
    wr(ADDR_P2_REC, 8'h00);
    p2 <= 1'b1;
    thr <= 8'hA0;
    start(1'b0);
    tick(20);
    bdone <= 1'b1;
    tick(1);
    bdone <= 1'b0;
    tick(20);
    echo_amp <= 8'hC0;
    wait_ready(3000);
    rdc(6'h12, 8'hFF, "open_w");
    rdc(6'h2F, 8'hFF, "slot7");
    echo_amp <= 8'h00;
    wr(ADDR_CTRL, 8'h03);
    rdc(ADDR_CTRL, 8'h03, "ctrl_wr");
    start(1'b1);
    echo_amp <= 8'hC0;
    wait_ready(30);
    rdc(6'h13, 8'hFF, "dump");
    echo_amp <= 8'h00;
    wr(ADDR_CTRL, 8'h01);
    tci_pat <= 1'b1;
    tick(1);
    tci_pat <= 1'b0;
    tick(4);
    `CHK("link_back", 1'b0, link)
    rdc(ADDR_STATUS, 8'h03, "flag2");
    close_out();
  end
endmodule
